// ---- src/dhp_pkg.sv ----
package dhp_pkg;
  localparam int DATA_W = 4;
  localparam int SEL_W  = 2;
  localparam int FREQ_W = 11;
  // register selection codes, from the latched address or from {ale, wr}
  localparam logic [1:0] SEL_TX   = 2'h0;
  localparam logic [1:0] SEL_RX   = 2'h1;
  localparam logic [1:0] SEL_CTRL = 2'h2;
  localparam logic [1:0] SEL_STAT = 2'h3;
  // control_bits fields
  localparam int CTRL_TONE_ON = 0;
  localparam int CTRL_DET_EN  = 1;
  localparam int CTRL_FAST    = 2;
  localparam int CTRL_PROG_ON = 3;
  // status_bits fields
  localparam int STAT_NEW  = 0;
  localparam int STAT_PROG = 1;
  localparam int STAT_FAX  = 2;
  localparam int STAT_VN   = 3;
  // reset values
  localparam logic [3:0] TX_RST   = 4'h0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [3:0] RX_RST   = 4'h0;
  // bus style strap values
  localparam logic STYLE_SEPARATE = 1'b1;
  localparam logic STYLE_SHARED   = 1'b0;
  // tone groups in Hz
  localparam logic [10:0] LOW_0  = 11'd697;
  localparam logic [10:0] LOW_1  = 11'd770;
  localparam logic [10:0] LOW_2  = 11'd852;
  localparam logic [10:0] LOW_3  = 11'd941;
  localparam logic [10:0] HIGH_0 = 11'd1209;
  localparam logic [10:0] HIGH_1 = 11'd1336;
  localparam logic [10:0] HIGH_2 = 11'd1477;
  localparam logic [10:0] HIGH_3 = 11'd1633;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } dhp_state_e;
endpackage : dhp_pkg

// ---- src/dhp_tone_table.sv ----
`timescale 1ns/1ps
module dhp_tone_table (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  input  wire logic [3:0]                  code_in,
  output logic      [dhp_pkg::FREQ_W-1:0]  low_hz_out,
  output logic      [dhp_pkg::FREQ_W-1:0]  high_hz_out
);
  logic [dhp_pkg::FREQ_W-1:0] low_nxt;
  logic [dhp_pkg::FREQ_W-1:0] high_nxt;

  always_comb begin
    low_nxt  = dhp_pkg::LOW_3;
    high_nxt = dhp_pkg::HIGH_3;
    case (code_in) // RQ12
      4'h1: begin low_nxt = dhp_pkg::LOW_0; high_nxt = dhp_pkg::HIGH_0; end
      4'h2: begin low_nxt = dhp_pkg::LOW_0; high_nxt = dhp_pkg::HIGH_1; end
      4'h3: begin low_nxt = dhp_pkg::LOW_0; high_nxt = dhp_pkg::HIGH_2; end
      4'h4: begin low_nxt = dhp_pkg::LOW_1; high_nxt = dhp_pkg::HIGH_0; end
      4'h5: begin low_nxt = dhp_pkg::LOW_1; high_nxt = dhp_pkg::HIGH_1; end
      4'h6: begin low_nxt = dhp_pkg::LOW_1; high_nxt = dhp_pkg::HIGH_2; end
      4'h7: begin low_nxt = dhp_pkg::LOW_2; high_nxt = dhp_pkg::HIGH_0; end
      4'h8: begin low_nxt = dhp_pkg::LOW_2; high_nxt = dhp_pkg::HIGH_1; end
      4'h9: begin low_nxt = dhp_pkg::LOW_2; high_nxt = dhp_pkg::HIGH_2; end
      4'hA: begin low_nxt = dhp_pkg::LOW_3; high_nxt = dhp_pkg::HIGH_1; end
      4'hB: begin low_nxt = dhp_pkg::LOW_3; high_nxt = dhp_pkg::HIGH_0; end
      4'hC: begin low_nxt = dhp_pkg::LOW_3; high_nxt = dhp_pkg::HIGH_2; end
      4'hD: begin low_nxt = dhp_pkg::LOW_0; high_nxt = dhp_pkg::HIGH_3; end
      4'hE: begin low_nxt = dhp_pkg::LOW_1; high_nxt = dhp_pkg::HIGH_3; end
      4'hF: begin low_nxt = dhp_pkg::LOW_2; high_nxt = dhp_pkg::HIGH_3; end
      default: begin low_nxt = dhp_pkg::LOW_3; high_nxt = dhp_pkg::HIGH_3; end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      low_hz_out  <= dhp_pkg::LOW_3;
      high_hz_out <= dhp_pkg::HIGH_3;
    end else begin
      low_hz_out  <= low_nxt;
      high_hz_out <= high_nxt;
    end
  end
endmodule : dhp_tone_table

// ---- src/dhp_port.sv ----
// What this block does
// (RQ1) strap picks separate or shared strobe style
// (RQ2) separate style: write on write-strobe rising edge
// (RQ3) separate style: read strobe low drives data
// (RQ4) shared style: strobe fall with write low writes
// (RQ5) shared style: strobe rise with write high reads
// (RQ6) power-down clears transmit code and control
// (RQ7) write-only and read-only registers, never crossed
// (RQ8) every register is four bits on D3..D0
// (RQ9) all sixteen transmit codes are accepted
// (RQ10) receive code uses the same encoding
// (RQ11) active tone frozen while transmission enabled
// (RQ12) code table maps digits to tone pairs
// (RQ13) selection 00 tx, 01 rx, 10 ctrl, 11 status
// (RQ14) control D0 and D3 switch tone outputs
// (RQ15) D2 fast detection; D1 gates fax/progress
// (RQ16) status D3 valid_n, D2 fax, D1 progress
// (RQ17) new-detect flag set on detect, cleared by read
`timescale 1ns/1ps
module dhp_port (
  input  wire logic                        clock_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        bus_style_select_in,
  input  wire logic                        power_down_pin_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        wr_n_in,
  input  wire logic                        rd_n_in,
  input  wire logic                        ale_in,
  input  wire logic [dhp_pkg::DATA_W-1:0]  data_in,
  output logic      [dhp_pkg::DATA_W-1:0]  data_out,
  output logic                             data_oe_n_out,
  input  wire logic [dhp_pkg::DATA_W-1:0]  rx_digit_bits_in,
  input  wire logic                        valid_digit_n_in,
  input  wire logic                        fax_detect_in,
  input  wire logic                        progress_detect_in,
  output logic                             tone_out_on_out,
  output logic                             progress_tone_out_on_out,
  output logic                             fast_detect_sel_out,
  output logic                             fax_detect_out,
  output logic                             progress_detect_out,
  output logic      [dhp_pkg::DATA_W-1:0]  tx_digit_bits_out,
  output logic      [dhp_pkg::FREQ_W-1:0]  low_hz_out,
  output logic      [dhp_pkg::FREQ_W-1:0]  high_hz_out
);
  typedef struct packed {
    dhp_pkg::dhp_state_e        st;
    logic [3:0]                 tx_code;
    logic [3:0]                 ctrl;
    logic [3:0]                 active;
    logic [3:0]                 rx_code;
    logic [3:0]                 dout;
    logic [1:0]                 addr;
    logic [1:0]                 sel;
    logic                       wr_q;
    logic                       rd_q;
    logic                       vn_q;
    logic                       fax_q;
    logic                       prog_q;
    logic                       flag;
  } dhp_regs_s;

  dhp_regs_s r;
  dhp_regs_s n;

  logic       sep;
  logic       fax_g;
  logic       prog_g;
  logic       wr_edge;
  logic       st_fall;
  logic       st_rise;
  logic       rd_start;
  logic       rd_end;
  logic       do_write;
  logic [1:0] wsel;
  logic [3:0] status_v;
  logic       det_set;

  assign sep     = (bus_style_select_in == dhp_pkg::STYLE_SEPARATE); // RQ1
  assign prog_g  = progress_detect_in & r.ctrl[dhp_pkg::CTRL_DET_EN]; // RQ15
  // a progress tone forces the fax indication low
  assign fax_g   = fax_detect_in & r.ctrl[dhp_pkg::CTRL_DET_EN] & ~prog_g; // RQ15
  assign wr_edge = !r.wr_q && wr_n_in;
  assign st_fall = r.rd_q && !rd_n_in;
  assign st_rise = !r.rd_q && rd_n_in;

  always_comb begin
    status_v = 4'h0;
    status_v[dhp_pkg::STAT_VN]   = r.vn_q; // RQ16
    status_v[dhp_pkg::STAT_FAX]  = r.fax_q; // RQ16
    status_v[dhp_pkg::STAT_PROG] = r.prog_q; // RQ16
    status_v[dhp_pkg::STAT_NEW]  = r.flag; // RQ17
  end

  always_comb begin
    do_write = 1'b0;
    wsel     = r.addr;
    rd_start = 1'b0;
    rd_end   = 1'b0;
    if (sep) begin
      do_write = !cs_n_in && wr_edge; // RQ2
      wsel     = r.addr; // RQ13
      rd_start = !cs_n_in && !rd_n_in; // RQ3
      rd_end   = cs_n_in || rd_n_in;
    end else begin
      do_write = !cs_n_in && !wr_n_in && st_fall; // RQ4
      wsel     = {ale_in, 1'b0}; // RQ13
      rd_start = !cs_n_in && wr_n_in && st_rise; // RQ5
      rd_end   = cs_n_in || !rd_n_in;
    end
  end

  assign det_set = (r.vn_q && !valid_digit_n_in) || (fax_g && !r.fax_q)
                || (prog_g && !r.prog_q);

  always_comb begin
    n         = r;
    n.wr_q    = wr_n_in;
    n.rd_q    = rd_n_in;
    n.vn_q    = valid_digit_n_in;
    n.fax_q   = fax_g;
    n.prog_q  = prog_g;
    n.rx_code = rx_digit_bits_in; // RQ10
    if (sep && ale_in) begin
      n.addr = data_in[1:0]; // RQ13
    end
    // only the two write-only selections store; the others are ignored
    if (do_write && wsel == dhp_pkg::SEL_TX) begin
      n.tx_code = data_in; // RQ9
    end
    if (do_write && wsel == dhp_pkg::SEL_CTRL) begin
      n.ctrl = data_in; // RQ7
    end
    if (power_down_pin_in) begin
      n.tx_code = dhp_pkg::TX_RST; // RQ6
      n.ctrl    = dhp_pkg::CTRL_RST; // RQ6
    end
    // latch the code only while the generator is off, so a write never glitches the tones
    if (!r.ctrl[dhp_pkg::CTRL_TONE_ON]) begin
      n.active = r.tx_code; // RQ11
    end
    if (r.flag && !r.vn_q && r.st == dhp_pkg::ST_READ && rd_end
        && r.sel == dhp_pkg::SEL_STAT) begin
      n.flag = 1'b0;
    end
    if (r.vn_q && !r.fax_q && !r.prog_q) begin
      n.flag = 1'b0; // RQ17
    end
    if (r.st == dhp_pkg::ST_READ && rd_end && r.sel == dhp_pkg::SEL_STAT) begin
      n.flag = 1'b0; // RQ17
    end
    if (det_set) begin
      n.flag = 1'b1; // RQ17
    end
    case (r.st)
      dhp_pkg::ST_IDLE: begin
        if (rd_start) begin
          n.st = dhp_pkg::ST_READ;
          n.sel = sep ? r.addr : {ale_in, 1'b1}; // RQ13
        end
      end
      dhp_pkg::ST_READ: begin
        if (rd_end) begin
          n.st = dhp_pkg::ST_IDLE;
        end
      end
      default: n.st = dhp_pkg::ST_IDLE;
    endcase
    case (n.sel)
      dhp_pkg::SEL_RX:   n.dout = r.rx_code; // RQ7
      dhp_pkg::SEL_STAT: n.dout = status_v; // RQ7
      default:           n.dout = 4'h0;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r         <= '0;
      r.st      <= dhp_pkg::ST_IDLE;
      r.tx_code <= dhp_pkg::TX_RST;
      r.ctrl    <= dhp_pkg::CTRL_RST;
      r.active  <= dhp_pkg::TX_RST;
      r.rx_code <= dhp_pkg::RX_RST;
      r.wr_q    <= 1'b1;
      r.rd_q    <= 1'b1;
      r.vn_q    <= 1'b1;
    end else begin
      r <= n;
    end
  end

  dhp_tone_table u_table (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .code_in     (r.active),
    .low_hz_out  (low_hz_out),
    .high_hz_out (high_hz_out)
  ); // RQ12

  assign data_out                 = r.dout; // RQ8
  assign data_oe_n_out            = (r.st != dhp_pkg::ST_READ); // RQ3
  assign tone_out_on_out          = r.ctrl[dhp_pkg::CTRL_TONE_ON]; // RQ14
  assign progress_tone_out_on_out = r.ctrl[dhp_pkg::CTRL_PROG_ON]; // RQ14
  assign fast_detect_sel_out      = r.ctrl[dhp_pkg::CTRL_FAST]; // RQ15
  assign fax_detect_out           = r.fax_q; // RQ15
  assign progress_detect_out      = r.prog_q; // RQ15
  assign tx_digit_bits_out        = r.active;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  sep_write_a: assert property (sep && !cs_n_in && !r.wr_q && wr_n_in // RQ2
      && r.addr == dhp_pkg::SEL_TX && !power_down_pin_in |=> r.tx_code == $past(data_in))
    else $error("separate write not captured");
  shared_write_a: assert property (!sep && !cs_n_in && !wr_n_in && r.rd_q && !rd_n_in // RQ4
      && ale_in && !power_down_pin_in |=> r.ctrl == $past(data_in))
    else $error("shared write not captured");
  sep_read_a: assert property (sep && r.st == dhp_pkg::ST_IDLE && !cs_n_in && !rd_n_in // RQ3
      |=> !data_oe_n_out)
    else $error("separate read not driven");
  shared_read_a: assert property (!sep && r.st == dhp_pkg::ST_IDLE && !cs_n_in && wr_n_in // RQ5
      && !r.rd_q && rd_n_in && !ale_in |=> !data_oe_n_out && data_out == $past(r.rx_code))
    else $error("shared read wrong");
  power_down_a: assert property (power_down_pin_in // RQ6
      |=> r.tx_code == dhp_pkg::TX_RST && r.ctrl == dhp_pkg::CTRL_RST)
    else $error("power down did not clear");
  tone_freeze_a: assert property (tone_out_on_out && $past(tone_out_on_out) // RQ11
      |-> $stable(tx_digit_bits_out))
    else $error("active code moved while enabled");
  gate_det_a: assert property (!r.ctrl[dhp_pkg::CTRL_DET_EN] // RQ15
      |=> !fax_detect_out && !progress_detect_out)
    else $error("detector not gated");
  flag_set_a: assert property (r.vn_q && !valid_digit_n_in |=> r.flag) // RQ17
    else $error("new detect flag not set");
  flag_drop_a: assert property (r.vn_q && !r.fax_q && !r.prog_q && !det_set |=> !r.flag) // RQ17
    else $error("new detect flag kept after signal gone");
  no_drive_a: assert property (cs_n_in |=> data_oe_n_out) // RQ3
    else $error("bus driven without select");

  sep_wr_c: cover property (sep && do_write);
  shared_rd_c: cover property (!sep && rd_start ##[1:8] rd_end);
  flag_clr_c: cover property (r.flag ##1 !r.flag);
endmodule : dhp_port

// ---- tb/dhp_host_model.sv ----
`timescale 1ns/1ps
module dhp_host_model (
  input  wire logic       clock_in,
  input  wire logic       style_in,
  input  wire logic [3:0] bus_in,
  output logic            cs_n_out,
  output logic            wr_n_out,
  output logic            rd_n_out,
  output logic            ale_out,
  output logic [3:0]      data_out
);
  initial begin
    cs_n_out = 1'b1;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    ale_out  = 1'b0;
    data_out = 4'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : step
  // strobe levels last two cycles or more; a released bus shows the inverse, not the old value
  task automatic acc(input logic rd, input logic [1:0] sel, input logic [3:0] wv,
                     output logic [3:0] rv);
    if (style_in) begin
      ale_out = 1'b1;
      data_out = {2'h0, sel};
      step(2);
      ale_out = 1'b0;
      step(1);
      cs_n_out = 1'b0;
      data_out = rd ? ~data_out : wv;
      rd_n_out = ~rd;
      wr_n_out = rd;
      step(3);
      rv = bus_in;
      rd_n_out = 1'b1;
      wr_n_out = 1'b1;
      step(2);
    end else begin
      cs_n_out = 1'b0;
      wr_n_out = rd;
      ale_out = sel[1];
      data_out = rd ? ~data_out : wv;
      step(2);
      rd_n_out = 1'b0;
      step(2);
      rd_n_out = 1'b1;
      step(3);
      rv = bus_in;
      if (rd) begin
        rd_n_out = 1'b0;
        step(2);
        cs_n_out = 1'b1;
        step(1);
        rd_n_out = 1'b1;
      end
    end
    cs_n_out = 1'b1;
    data_out = ~data_out;
    step(2);
  endtask : acc
endmodule : dhp_host_model

// ---- tb/dtmf_host_register_port_bench.sv ----
`timescale 1ns/1ps
module dtmf_host_register_port_bench;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        style    = 1'b1;
  logic        pd       = 1'b0;
  logic        vn       = 1'b1;
  logic        fax      = 1'b0;
  logic        prog     = 1'b0;
  logic [3:0]  rx       = 4'h0;
  logic        cs_n, wr_n, rd_n, ale, oe_n, tone_on, prog_on, fast, fax_o, prog_o;
  logic [3:0]  host_d, dout, txo, rv, bus, ctl;
  logic [10:0] lo, hi;
  logic [21:0] ep;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          seed        = 65;
  logic [10:0] lows [4] = '{11'd697, 11'd770, 11'd852, 11'd941};
  logic [10:0] highs[4] = '{11'd1209, 11'd1336, 11'd1477, 11'd1633};

  always #20 clock_in = ~clock_in;
  // wire level of the shared data lines
  assign bus = oe_n ? host_d : dout;

  dhp_port i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .bus_style_select_in(style),
    .power_down_pin_in(pd), .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n), .ale_in(ale),
    .data_in(bus), .data_out(dout), .data_oe_n_out(oe_n), .rx_digit_bits_in(rx),
    .valid_digit_n_in(vn), .fax_detect_in(fax), .progress_detect_in(prog),
    .tone_out_on_out(tone_on), .progress_tone_out_on_out(prog_on),
    .fast_detect_sel_out(fast), .fax_detect_out(fax_o), .progress_detect_out(prog_o),
    .tx_digit_bits_out(txo), .low_hz_out(lo), .high_hz_out(hi));

  dhp_host_model i_host (.clock_in(clock_in), .style_in(style), .bus_in(bus),
    .cs_n_out(cs_n), .wr_n_out(wr_n), .rd_n_out(rd_n), .ale_out(ale), .data_out(host_d));

  function automatic logic [21:0] tone_pair(input logic [3:0] c);
    int r;
    int k;
    r = (int'(c) - 1) / 3;
    k = (int'(c) - 1) % 3;
    if (c == 4'h0) begin
      r = 3;
      k = 3;
    end else if (c > 4'hC) begin
      r = int'(c) - 13;
      k = 3;
    end else if (c > 4'h9) begin
      k = (c == 4'hA) ? 1 : (c == 4'hB) ? 0 : 2;
    end
    return {lows[r], highs[k]};
  endfunction : tone_pair

  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("mismatches %0d, checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    #200000;
    bad_count++;
    $display("unexpected watchdog: expected done, seen hang");
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clock_in);
    #2;
    rst_n_in = 1'b1;
    i_host.step(1);
    chk("data_oe_n", 11'h1, 11'(oe_n));
    chk("low_hz", 11'd941, lo);
    chk("high_hz", 11'd1633, hi);
    for (int s = 1; s >= 0; s--) begin
      style = s[0];
      ctl = 4'($random(seed)) & 4'hE;
      i_host.acc(1'b0, dhp_pkg::SEL_CTRL, ctl, rv);
      chk("control", 11'({ctl[3], ctl[2], ctl[0]}), 11'({prog_on, fast, tone_on}));
      for (int c = 0; c < 16; c++) begin
        i_host.acc(1'b0, dhp_pkg::SEL_TX, 4'(c), rv);
        ep = tone_pair(4'(c));
        chk("tx_digit_bits", 11'(c), 11'(txo));
        chk("low_hz", ep[21:11], lo);
        chk("high_hz", ep[10:0], hi);
        rx = 4'($random(seed));
        i_host.acc(1'b1, dhp_pkg::SEL_RX, 4'h0, rv);
        chk("rx_digit_bits", 11'(rx), 11'(rv));
      end
      if (s == 1) begin
        i_host.acc(1'b0, dhp_pkg::SEL_RX, ~rx, rv);
        i_host.acc(1'b1, dhp_pkg::SEL_RX, 4'h0, rv);
        chk("rx after write", 11'(rx), 11'(rv));
        i_host.acc(1'b1, dhp_pkg::SEL_TX, 4'h0, rv);
        chk("write-only read", 11'h0, 11'(rv));
      end
    end
    i_host.acc(1'b0, dhp_pkg::SEL_CTRL, 4'h1, rv);
    i_host.acc(1'b0, dhp_pkg::SEL_TX, 4'h5, rv);
    chk("frozen tx", 11'hF, 11'(txo));
    pd = 1'b1;
    i_host.step(2);
    pd = 1'b0;
    i_host.step(2);
    chk("power-down", 11'h0, 11'({tone_on, txo}));
    i_host.acc(1'b0, dhp_pkg::SEL_CTRL, 4'h2, rv);
    vn = 1'b0;
    i_host.step(2);
    i_host.acc(1'b1, dhp_pkg::SEL_STAT, 4'h0, rv);
    chk("status detect", 11'h1, 11'(rv));
    i_host.acc(1'b1, dhp_pkg::SEL_STAT, 4'h0, rv);
    chk("status reread", 11'h0, 11'(rv));
    fax = 1'b1;
    prog = 1'b1;
    i_host.step(2);
    chk("detector outs", 11'h1, 11'({fax_o, prog_o}));
    i_host.acc(1'b1, dhp_pkg::SEL_STAT, 4'h0, rv);
    chk("status tones", 11'h3, 11'(rv));
    i_host.acc(1'b0, dhp_pkg::SEL_CTRL, 4'h0, rv);
    chk("detectors gated", 11'h0, 11'({fax_o, prog_o}));
    // a new digit sets the flag, and its loss clears it without any status read
    vn = 1'b1;
    i_host.step(2);
    vn = 1'b0;
    i_host.step(2);
    vn = 1'b1;
    i_host.step(3);
    i_host.acc(1'b1, dhp_pkg::SEL_STAT, 4'h0, rv);
    chk("status dropped", 11'h8, 11'(rv));
    tally_and_finish();
  end
endmodule : dtmf_host_register_port_bench
